// >>> src/fwsr_top.sv
// Notes on behaviour
// (R1) Status check starts with two back-to-back reads, comparing toggle bit one.
// (R2) Once toggling stops, the next read returns array data.
// (R3) Toggling with timeout flag high: check toggling once more.
// (R4) Still toggling after timeout: failure, write the reset command.
// (R5) Toggling with timeout low: restart from the first double read.
// (R6) Device raises the timeout flag when its pulse limit is exceeded.
// (R7) Programming a 0 back to 1 halts and then raises the timeout flag.
// (R8) After a timeout failure the host writes the reset command.
// (R9) Erase window flag reads 0 while sectors accepted, 1 once erase starts.
// (R10) Each extra sector erase command restarts the device's window.
// (R11) Extra erase commands under 50 us apart need no window check.
// (R12) With the window flag at 1 the device ignores all but suspend.
// (R13) With the window flag at 0 the device takes extra sectors.
// (R14) After an erase command confirm acceptance by toggling, then read window; only the guard order does, the command order skips both.
// (R15) Read window flag before and after extra commands; high after means doubt.
// (R16) Status reads use an address inside the busy bank.
// (R17) Reads to an idle bank return array data, not status.
// (R18) Toggle bit one inverts on each read while busy.
// (R19) Toggle bit two inverts on reads within sectors chosen for erase.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fwsr_top #(
  parameter int AW = 19
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ,
  // Flash pins
  output logic [AW-1:0] FL_ADDR,
  output logic FL_CE_N,
  output logic FL_OE_N,
  output logic FL_WE_N,
  output logic [7:0] FL_DQ_O,
  output logic FL_DQ_OE_N,
  input wire logic [7:0] FL_DQ_I,
  input wire logic READY_BUSY_OUTPUT
);
  import fwsr_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_RD1, S_RD2, S_RECHK, S_ARRAY, S_RESET,
    S_CMD, S_GPRE, S_GWR, S_GT1, S_GT2, S_GPOST
  } fwsr_state_t;

  fwsr_state_t st_ff, nxt_st;
  logic issued_ff;
  logic [AW-1:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] first_ff;
  logic [7:0] last_ff;
  logic [7:0] array_ff;
  logic ok_ff;
  logic fail_ff;
  logic reject_ff;
  logic window_ff;
  logic abort_ff;
  logic rb_ff;
  logic [11:0] gap_ff;
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] irq_stat;
  logic [EV_N-1:0] irq_mask;
  logic cyc_idle;
  logic cyc_done;
  logic [7:0] cyc_rdata;

  // Toggle test against the stored previous read
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    toggled = a[BIT_TOGGLE_ONE] ^ b[BIT_TOGGLE_ONE];
  endfunction

  // APB decode; no wait states
  wire apb_acc = PSEL && PENABLE;
  wire apb_wr = apb_acc && PWRITE;
  wire hit_ctrl = (PADDR == OFF_CTRL);
  wire hit_addr = (PADDR == OFF_ADDR);
  wire hit_data = (PADDR == OFF_DATA);
  wire hit_stat = (PADDR == OFF_STAT);
  wire hit_istat = (PADDR == OFF_IRQ_STAT);
  wire hit_imask = (PADDR == OFF_IRQ_MASK);
  wire mapped = hit_ctrl | hit_addr | hit_data | hit_stat | hit_istat | hit_imask;
  wire busy = (st_ff != S_IDLE);
  wire ctrl_wr = apb_wr && hit_ctrl;
  // Orders other than abort are only taken while idle; address and data stay frozen while busy
  wire go_poll = ctrl_wr && !busy && PWDATA[CTL_POLL];
  wire go_cmd = ctrl_wr && !busy && PWDATA[CTL_CMD];
  wire go_guard = ctrl_wr && !busy && PWDATA[CTL_GUARD];
  wire go_reset = ctrl_wr && !busy && PWDATA[CTL_RESET];
  wire abort_req = ctrl_wr && busy && PWDATA[CTL_ABORT];

  assign PREADY = 1'b1;
  assign PSLVERR = apb_acc && !mapped;

  // (R11) Commands closer than this need no window check
  wire fast_gap = (gap_ff < 12'(WIN_CYC));
  wire [31:0] stat_word = {8'h00, array_ff, last_ff, 1'b0, fast_gap, rb_ff, window_ff,
    reject_ff, fail_ff, ok_ff, busy};
  wire [31:0] rd_mux =
    hit_ctrl ? RST_WORD :
    hit_addr ? 32'(addr_ff) :
    hit_data ? {24'h000000, data_ff} :
    hit_stat ? stat_word :
    hit_istat ? 32'(irq_stat) :
    hit_imask ? 32'(irq_mask) : RST_WORD;
  assign PRDATA = (apb_acc && !PWRITE) ? rd_mux : RST_WORD;

  // Bus cycle request for the current state
  wire op_state = busy;
  wire cyc_start = op_state && !issued_ff && cyc_idle;
  wire cyc_we = (st_ff == S_RESET) || (st_ff == S_CMD) || (st_ff == S_GWR);
  wire [7:0] cyc_wdata = (st_ff == S_RESET) ? RESET_CMD_BYTE : data_ff;
  wire tog_now = toggled(cyc_rdata, first_ff);
  wire to_now = cyc_rdata[BIT_TIMEOUT];
  wire win_now = cyc_rdata[BIT_ERASE_WINDOW];

  fwsr_cycle #(.AW(AW)) u_cycle (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .start(cyc_start),
    .we(cyc_we),
    // (R16) Status reads go to the bank address held in the address register
    .addr(addr_ff),
    .wdata(cyc_wdata),
    .idle(cyc_idle),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(FL_ADDR),
    .fl_ce_n(FL_CE_N),
    .fl_oe_n(FL_OE_N),
    .fl_we_n(FL_WE_N),
    .fl_dq_o(FL_DQ_O),
    .fl_dq_oe_n(FL_DQ_OE_N),
    .fl_dq_i(FL_DQ_I)
  );

  // Next state on an order while idle and on completion of each flash cycle
  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    unique case (st_ff)
      S_IDLE: begin
        if (go_poll) begin
          nxt_st = S_RD1;
        end else if (go_guard) begin
          nxt_st = S_GPRE;
        end else if (go_cmd) begin
          nxt_st = S_CMD;
        end else if (go_reset) begin
          nxt_st = S_RESET;
        end
      end
      S_RD1: begin
        if (cyc_done) begin
          nxt_st = S_RD2;
        end
      end
      S_RD2: begin
        if (cyc_done) begin
          // (R2) Toggle stopped: fetch array data
          if (!tog_now) begin
            nxt_st = S_ARRAY;
          // (R3) Timeout seen: one more check
          end else if (to_now) begin
            nxt_st = S_RECHK;
          // (R5) Restart the double read, or return to idle if an abort is pending
          end else if (abort_ff) begin
            nxt_st = S_IDLE;
          end else begin
            nxt_st = S_RD1;
          end
        end
      end
      S_RECHK: begin
        if (cyc_done) begin
          // (R4) Still toggling: failed, reset
          nxt_st = tog_now ? S_RESET : S_ARRAY;
        end
      end
      S_ARRAY: begin
        if (cyc_done) begin
          nxt_st = S_IDLE;
          ev[EV_OK] = 1'b1;
        end
      end
      S_RESET: begin
        if (cyc_done) begin
          nxt_st = S_IDLE;
          ev[EV_FAIL] = fail_ff;
        end
      end
      S_CMD: begin
        if (cyc_done) begin
          nxt_st = S_IDLE;
        end
      end
      S_GPRE: begin
        if (cyc_done) begin
          // (R15) Window already closed: command not sent
          if (win_now) begin
            nxt_st = S_IDLE;
            ev[EV_REJECT] = 1'b1;
          end else begin
            nxt_st = S_GWR;
          end
        end
      end
      S_GWR: begin
        if (cyc_done) begin
          nxt_st = S_GT1;
        end
      end
      S_GT1: begin
        if (cyc_done) begin
          nxt_st = S_GT2;
        end
      end
      S_GT2: begin
        // (R14) Acceptance by toggling before the window read
        if (cyc_done) begin
          if (tog_now || abort_ff) begin
            nxt_st = S_GPOST;
          end else begin
            nxt_st = S_GT1;
          end
        end
      end
      S_GPOST: begin
        if (cyc_done) begin
          nxt_st = S_IDLE;
          // (R15) Closed after the command: it may have been lost
          ev[EV_REJECT] = win_now;
        end
      end
    endcase
  end

  // Sequencer state and cycle bookkeeping
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_ff <= S_IDLE;
      issued_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (cyc_start) begin
        issued_ff <= 1'b1;
      end else if (cyc_done) begin
        issued_ff <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      addr_ff <= '0;
      data_ff <= 8'h00;
    end else if (apb_wr && !busy) begin
      if (hit_addr) begin
        addr_ff <= PWDATA[AW-1:0];
      end
      if (hit_data) begin
        data_ff <= PWDATA[7:0];
      end
    end
  end

  // Abort request and ready/busy pin sample
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      abort_ff <= 1'b0;
      rb_ff <= 1'b0;
    end else begin
      rb_ff <= READY_BUSY_OUTPUT;
      if (!busy) begin
        abort_ff <= 1'b0;
      end else if (abort_req) begin
        abort_ff <= 1'b1;
      end
    end
  end

  // (R1) First read of each pair is the toggle reference; the second read is the recheck's reference
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      first_ff <= 8'h00;
      last_ff <= 8'h00;
      array_ff <= 8'h00;
    end else if (cyc_done && !cyc_we) begin
      last_ff <= cyc_rdata;
      if (st_ff == S_RD1 || st_ff == S_GT1 || st_ff == S_RD2) begin
        first_ff <= cyc_rdata;
      end
      // (R2) Array data taken on the read after toggling stops
      if (st_ff == S_ARRAY) begin
        array_ff <= cyc_rdata;
      end
    end
  end

  // Outcome flags; ok, fail and reject cleared when a new order starts, window flag kept until the next window read
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ok_ff <= 1'b0;
      fail_ff <= 1'b0;
      reject_ff <= 1'b0;
      window_ff <= 1'b0;
    end else begin
      if (st_ff == S_IDLE && nxt_st != S_IDLE) begin
        ok_ff <= 1'b0;
        fail_ff <= 1'b0;
        reject_ff <= 1'b0;
      end
      if (ev[EV_OK]) begin
        ok_ff <= 1'b1;
      end
      // (R8) Failure marks the reset write as recovery
      if (st_ff == S_RECHK && cyc_done && tog_now) begin
        fail_ff <= 1'b1;
      end
      if (ev[EV_REJECT]) begin
        reject_ff <= 1'b1;
      end
      if ((st_ff == S_GPRE || st_ff == S_GPOST) && cyc_done) begin
        window_ff <= win_now;
      end
    end
  end

  // (R11) Time since the last command write, saturating
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      gap_ff <= 12'hfff;
    end else if (cyc_done && (st_ff == S_CMD || st_ff == S_GWR)) begin
      gap_ff <= 12'h000;
    end else if (gap_ff != 12'hfff) begin
      gap_ff <= gap_ff + 12'h001;
    end
  end

  fwsr_irq #(.N(EV_N)) u_irq (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .ev(ev),
    .clr_we(apb_wr && hit_istat),
    .mask_we(apb_wr && hit_imask),
    .wdata(PWDATA[EV_N-1:0]),
    .stat(irq_stat),
    .mask(irq_mask),
    .irq(IRQ)
  );

endmodule
`default_nettype wire

// >>> src/fwsr_pkg.sv
package fwsr_pkg;

  // Clock
  localparam int CLK_NS = 20;

  // Flash cycle timing in ns and derived cycle counts (least times round up)
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_GAP_NS = 20;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;

  // Gap between extra sector erase commands that needs no window check
  localparam int T_WIN_US = 50;
  localparam int WIN_CYC = (T_WIN_US * 1000) / CLK_NS;

  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // Control bits
  localparam int CTL_POLL = 0;
  localparam int CTL_CMD = 1;
  localparam int CTL_GUARD = 2;
  localparam int CTL_ABORT = 3;
  localparam int CTL_RESET = 4;

  // Status byte bit positions on the flash data pins
  localparam int BIT_TOGGLE_TWO = 2;
  localparam int BIT_ERASE_WINDOW = 3;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_TOGGLE_ONE = 6;
  localparam int BIT_POLLING = 7;

  // Event bits
  localparam int EV_OK = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_REJECT = 2;
  localparam int EV_N = 3;

  localparam logic [7:0] RESET_CMD_BYTE = 8'hf0;
  localparam logic [31:0] RST_WORD = 32'h00000000;

endpackage

// >>> src/fwsr_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module fwsr_cycle #(
  parameter int AW = 19
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request
  input wire logic start,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic idle,
  output logic done,
  output logic [7:0] rdata,
  // Flash pins
  output logic [AW-1:0] fl_addr,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic [7:0] fl_dq_o,
  output logic fl_dq_oe_n,
  input wire logic [7:0] fl_dq_i
);
  import fwsr_pkg::*;

  typedef enum logic [1:0] {FC_IDLE, FC_ACT, FC_GAP} fwsr_cyc_t;
  fwsr_cyc_t st_ff;
  logic [3:0] cnt_ff;
  logic we_ff;
  logic done_ff;

  // Every read ends with a strobe rise so the device sees a new read cycle
  wire act = (st_ff == FC_ACT);
  wire [3:0] act_len = we_ff ? 4'(WP_CYC) : 4'(ACC_CYC);
  wire act_end = act && (cnt_ff == act_len - 4'h1);
  wire gap_end = (st_ff == FC_GAP) && (cnt_ff == 4'(GAP_CYC - 1));

  assign idle = (st_ff == FC_IDLE);
  assign done = done_ff;
  assign fl_ce_n = !act;
  assign fl_oe_n = !(act && !we_ff);
  assign fl_we_n = !(act && we_ff);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= FC_IDLE;
      cnt_ff <= 4'h0;
      we_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata <= 8'h00;
      fl_addr <= '0;
      fl_dq_o <= 8'h00;
      fl_dq_oe_n <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      cnt_ff <= cnt_ff + 4'h1;
      unique case (st_ff)
        FC_IDLE: begin
          cnt_ff <= 4'h0;
          if (start) begin
            st_ff <= FC_ACT;
            we_ff <= we;
            fl_addr <= addr;
            fl_dq_o <= wdata;
            fl_dq_oe_n <= !we;
          end
        end
        FC_ACT: begin
          if (act_end) begin
            st_ff <= FC_GAP;
            cnt_ff <= 4'h0;
            if (!we_ff) begin
              rdata <= fl_dq_i;
            end
          end
        end
        FC_GAP: begin
          // Data held through the gap for write hold time
          if (gap_end) begin
            st_ff <= FC_IDLE;
            fl_dq_oe_n <= 1'b1;
            done_ff <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> src/fwsr_irq.sv
`timescale 1ns/1ps
`default_nettype none
module fwsr_irq #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Events and software access
  input wire logic [N-1:0] ev,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [N-1:0] wdata,
  // State
  output logic [N-1:0] stat,
  output logic [N-1:0] mask,
  output logic irq
);
  // A new event beats a clear of the same bit in the same cycle
  wire [N-1:0] clr = clr_we ? wdata : '0;
  wire [N-1:0] nxt_stat = (stat & ~clr) | ev;

  assign irq = |(stat & mask);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat <= '0;
      mask <= '0;
    end else begin
      stat <= nxt_stat;
      if (mask_we) begin
        mask <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/fwsr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fwsr_monitor #(
  parameter int AW = 19
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ,
  // Flash pins
  input wire logic [AW-1:0] FL_ADDR,
  input wire logic FL_CE_N,
  input wire logic FL_OE_N,
  input wire logic FL_WE_N,
  input wire logic [7:0] FL_DQ_O,
  input wire logic FL_DQ_OE_N,
  input wire logic [7:0] FL_DQ_I,
  input wire logic READY_BUSY_OUTPUT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property p_ready; PSEL && PENABLE |-> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("access phase without ready");
  property p_err; PSEL && PENABLE && PADDR > 8'h14 |-> PSLVERR && PRDATA == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_idle; !(PSEL && PENABLE) |-> PRDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access phase");
  property p_rd_len; $fell(FL_OE_N) |-> (!FL_OE_N && !FL_CE_N)[*4] ##1 FL_OE_N; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
  property p_rd_gap; $rose(FL_OE_N) |-> FL_CE_N && FL_WE_N; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("reads not separated");
  property p_wr_len; $fell(FL_WE_N) |-> (!FL_WE_N && !FL_DQ_OE_N)[*2] ##1 (FL_WE_N && !FL_DQ_OE_N); endproperty
  a_wr_len: assert property (p_wr_len) else $error("write pulse wrong");
  property p_addr; !FL_OE_N && !$fell(FL_OE_N) |-> $stable(FL_ADDR); endproperty
  a_addr: assert property (p_addr) else $error("address moved in read");
  // Controller never fights the device for the data pins
  property p_excl; !FL_OE_N |-> FL_WE_N && FL_DQ_OE_N; endproperty
  a_excl: assert property (p_excl) else $error("drive during read");
  property p_wdata; !FL_WE_N && !$fell(FL_WE_N) |-> $stable(FL_DQ_O); endproperty
  a_wdata: assert property (p_wdata) else $error("write data moved");
  c_read: cover property ($fell(FL_OE_N));
  c_write: cover property ($fell(FL_WE_N));
  c_irq: cover property ($rose(IRQ));
endmodule
bind fwsr_top fwsr_monitor #(.AW(AW)) u_mon (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .IRQ(IRQ), .FL_ADDR(FL_ADDR), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_DQ_O(FL_DQ_O),
  .FL_DQ_OE_N(FL_DQ_OE_N), .FL_DQ_I(FL_DQ_I), .READY_BUSY_OUTPUT(READY_BUSY_OUTPUT));
`default_nettype wire

// >>> sim/fwsr_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model #(
  parameter int AW = 19,
  parameter int WIN_NS = 60000
) (
  // Flash pins
  input wire logic [AW-1:0] fl_addr,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic [7:0] fl_dq_o,
  output logic [7:0] fl_dq_i,
  output logic ready_busy
);
  logic busy = 1'b0;
  logic erase = 1'b0;
  logic bank = 1'b0;
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic tout = 1'b0;
  logic win;
  logic [7:0] sects = 8'h00;
  int left = 0;
  int mode = 0;
  realtime t_win = 0;
  assign ready_busy = ~busy;
  initial fl_dq_i = 8'h00;
  // Mode 0 completes, 1 completes on the read after the limit trips, 2 never completes
  task automatic start_op(input logic b, input int n, input int m);
    busy = 1'b1;
    bank = b;
    left = n;
    mode = m;
    tout = 1'b0;
    erase = 1'b0;
  endtask
  always @(negedge fl_oe_n) begin
    win = ($realtime - t_win) >= WIN_NS;
    if (!busy || fl_addr[AW-1] != bank) begin
      fl_dq_i = fl_addr[7:0] ^ 8'ha5;
    end else begin
      if (left > 0 || mode == 2) begin
        tog1 = ~tog1;
        if (erase && sects[fl_addr[AW-2 -: 3]]) tog2 = ~tog2;
        if ((!erase || win) && left > 0) left = left - 1;
        if (left == 0 && mode != 0) tout = 1'b1;
      end else begin
        busy = 1'b0;
      end
      fl_dq_i = {1'b0, tog1, tout, 1'b0, erase && win, tog2, 2'b00};
    end
  end
  // No pull on the data pins: a released bus shows garbage
  always @(posedge fl_oe_n) fl_dq_i = ~fl_dq_i;
  always @(posedge fl_we_n) begin
    if (fl_dq_o == 8'hf0) begin
      busy = 1'b0;
      tout = 1'b0;
      erase = 1'b0;
    end else if (fl_dq_o == 8'h30 && !busy) begin
      start_op(fl_addr[AW-1], 4, 0);
      erase = 1'b1;
      sects = 8'h00;
      sects[fl_addr[AW-2 -: 3]] = 1'b1;
      t_win = $realtime;
    end else if (fl_dq_o == 8'h30 && erase && ($realtime - t_win) < WIN_NS) begin
      sects[fl_addr[AW-2 -: 3]] = 1'b1;
      t_win = $realtime;
    end
  end
endmodule
`default_nettype wire

// >>> sim/fwsr_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fwsr_bench;
  import fwsr_pkg::*;
  localparam int AW = 19;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, irq, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n, rdy;
  logic [AW-1:0] fl_addr, a;
  logic [7:0] fl_dq_o, fl_dq_i;
  logic [7:0] offs[4] = '{OFF_CTRL, OFF_IRQ_STAT, OFF_IRQ_MASK, 8'h20};
  logic [63:0] q[$];
  logic [63:0] e;
  int n_errors = 0;
  int compares = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  fwsr_top #(.AW(AW)) u_dut (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
    .FL_ADDR(fl_addr), .FL_CE_N(fl_ce_n), .FL_OE_N(fl_oe_n), .FL_WE_N(fl_we_n), .FL_DQ_O(fl_dq_o),
    .FL_DQ_OE_N(fl_dq_oe_n), .FL_DQ_I(fl_dq_i), .READY_BUSY_OUTPUT(rdy));
  fwsr_flash_model #(.AW(AW), .WIN_NS(60000)) u_dev (.fl_addr(fl_addr), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_dq_o(fl_dq_o), .fl_dq_i(fl_dq_i), .ready_busy(rdy));
  task automatic complete_run();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  // Read results are matched against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      if (e[63:32] != 32'h0) chk(prdata, e[31:0], e[63:32]);
    end
  end
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rv);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, ad, d, x);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] m, output logic [31:0] rv);
    q.push_back({m, ex});
    apb(1'b0, ad, 32'h0, rv);
  endtask
  task automatic wait_idle();
    logic [31:0] x;
    int k;
    k = 0;
    do begin
      rd(OFF_STAT, 32'h0, 32'h0, x);
      k++;
    end while (x[0] !== 1'b0 && k < 5000);
    if (k >= 5000) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic poll(input logic b, input int len, input int m);
    a = AW'($urandom);
    a[AW-1] = b;
    u_dev.start_op(b, len, m);
    wr(OFF_ADDR, 32'(a));
    wr(OFF_CTRL, 32'h1 << CTL_POLL);
    wait_idle();
  endtask
  function automatic logic [31:0] okw();
    return {8'h00, a[7:0] ^ 8'ha5, 16'h0022};
  endfunction
  initial begin
    void'($urandom(45));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(OFF_STAT, 32'h20, 32'h27, r);
    foreach (offs[i]) rd(offs[i], 32'h0, 32'hffffffff, r);
    wr(OFF_IRQ_MASK, 32'h2);
    rd(OFF_IRQ_MASK, 32'h2, 32'h7, r);
    for (int i = 0; i < 4; i++) begin
      poll(i[0], $urandom_range(2, 9), 0);
      rd(OFF_STAT, okw(), 32'h00ff0027, r);
    end
    chk({31'h0, irq}, 32'h0, 32'h1);
    // Limit trips on the second read, so the recheck path is taken
    poll(1'b1, 2, 1);
    rd(OFF_STAT, okw(), 32'h00ff0027, r);
    poll(1'b0, 2, 2);
    rd(OFF_STAT, 32'h24, 32'h27, r);
    chk({31'h0, irq}, 32'h1, 32'h1);
    wr(OFF_IRQ_STAT, 32'h2);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0, 32'h1);
    rd(OFF_IRQ_STAT, 32'h1, 32'h7, r);
    // Abort mid-poll, then restart from the first pair
    u_dev.start_op(1'b0, 1000, 0);
    wr(OFF_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    chk(32'(fl_addr), 32'(a), 32'h0007ffff);
    rd(OFF_STAT, 32'h1, 32'h21, r);
    wr(OFF_CTRL, 32'h1 << CTL_ABORT);
    wait_idle();
    rd(OFF_STAT, 32'h0, 32'h7, r);
    u_dev.left = 1;
    wr(OFF_CTRL, 32'h1);
    wait_idle();
    rd(OFF_STAT, okw(), 32'h00ff0027, r);
    // Sector erase, extra sector inside then outside the window
    a = {1'b1, 3'd1, 15'h0};
    wr(OFF_ADDR, 32'(a));
    wr(OFF_DATA, 32'h30);
    wr(OFF_CTRL, 32'h1 << CTL_CMD);
    wait_idle();
    a[AW-2 -: 3] = 3'd2;
    wr(OFF_ADDR, 32'(a));
    wr(OFF_CTRL, 32'h1 << CTL_GUARD);
    wait_idle();
    rd(OFF_STAT, 32'h40, 32'h58, r);
    rd(OFF_IRQ_STAT, 32'h0, 32'h4, r);
    repeat (3000) @(posedge clk);
    rd(OFF_STAT, 32'h0, 32'h40, r);
    wr(OFF_CTRL, 32'h1 << CTL_GUARD);
    wait_idle();
    rd(OFF_IRQ_STAT, 32'h4, 32'h4, r);
    rd(OFF_STAT, 32'h18, 32'h18, r);
    wr(OFF_CTRL, 32'h1);
    wait_idle();
    rd(OFF_STAT, okw(), 32'h00ff0027, r);
    // Plain reset order: no outcome flag and no event
    wr(OFF_CTRL, 32'h1 << CTL_RESET);
    wait_idle();
    rd(OFF_STAT, 32'h20, 32'h2f, r);
    rd(OFF_IRQ_STAT, 32'h5, 32'h7, r);
    complete_run();
  end
endmodule
`default_nettype wire
